// ---- verilog/imwd_consts.vh ----
// Constants for the interrupt mask and wake delay block.
// Assumes inclusion by bare name from the design file.
`ifndef IMWD_CONSTS_VH
`define IMWD_CONSTS_VH
// Register addresses
`define IMWD_ADDR_REQ 8'hFA
`define IMWD_ADDR_MASK 8'hFB
`define IMWD_ADDR_STOPREC 8'h0B
`define IMWD_ADDR_STAT 8'hE0
`define IMWD_ADDR_IEN 8'hE1
// Field positions
`define IMWD_MASK_MASTER 7
`define IMWD_MASK_RSVD 6
`define IMWD_STOPREC_DLY 5
// Reset values
`define IMWD_MASK_RST 8'h40
`define IMWD_REQ_RST 6'h00
`define IMWD_STOPREC_RST 8'h20
// Timing
`define IMWD_CLK_HZ 10000000
`define IMWD_TPOR_US 5000
`define IMWD_TPOR_CYC ((`IMWD_TPOR_US * (`IMWD_CLK_HZ / 1000000)))
`endif

// ---- verilog/imwd_top.v ----
// Interrupt mask, request bits and stop wake delay.
// Assumes a plain register port with one-cycle read latency and srst synchronous.
// All inputs come from logic on the system clock.
// Unmapped addresses read as zero and ignore writes.
//
// Design decision made here: the strobed register port.

`timescale 1ns/10ps
`default_nettype none
`include "imwd_consts.vh"

module imwd_top #(
   parameter NSRC = 6,
   parameter TPOR_CYC = `IMWD_TPOR_CYC
) (
   input wire clock, // System clock
   input wire srst, // Synchronous reset, high
   input wire [7:0] reg_addr, // Register address
   input wire [7:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   output reg [7:0] reg_rdata, // Read data, cycle after strobe
   input wire [NSRC-1:0] src_event, // Source request pulses, same clock
   input wire enable_interrupts_instr, // Enable instruction pulse
   input wire disable_interrupts_instr, // Disable instruction pulse
   input wire [NSRC-1:0] service_ack, // Core services source pulse
   output wire [NSRC-1:0] core_req, // Gated requests to core
   output wire core_irq, // Any gated request
   input wire stop_wake, // Wake event from stop mode
   output reg exec_enable, // Core may execute
   output wire irq // Level interrupt from sticky status
);
   // ------------------------------------------------------------
   // Local constants
   // ------------------------------------------------------------
   localparam [1:0] ST_RUN = 2'b00; // Core may execute
   localparam [1:0] ST_WAIT = 2'b01; // Wake delay counting
   localparam [31:0] DLY_LAST = TPOR_CYC - 1; // Final count of the wake delay
   localparam [31:0] DLY_START = 32'h00000000; // Count on entry to the delay
   localparam [31:0] DLY_STEP = 32'h00000001; // Count increment

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] mask_q;
   reg [NSRC-1:0] req_q;
   reg [7:0] stoprec_q;
   reg [1:0] stat_q;
   reg [1:0] ien_q;
   reg [31:0] dly_cnt_q;
   reg [1:0] wake_st_q;
   reg core_irq_dly_q;

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   reg [7:0] mask_d;
   reg [NSRC-1:0] req_d;
   reg [7:0] stoprec_d;
   reg [1:0] stat_d;
   reg [1:0] ien_d;
   reg [31:0] dly_cnt_d;
   reg [1:0] wake_st_d;
   reg exec_enable_d;
   reg core_irq_dly_d;
   reg [7:0] rdata_d;
   integer k;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire sel_req = (reg_addr == `IMWD_ADDR_REQ);
   wire sel_mask = (reg_addr == `IMWD_ADDR_MASK);
   wire sel_stoprec = (reg_addr == `IMWD_ADDR_STOPREC);
   wire sel_stat = (reg_addr == `IMWD_ADDR_STAT);
   wire sel_ien = (reg_addr == `IMWD_ADDR_IEN);

   // ------------------------------------------------------------
   // Write strobes
   // ------------------------------------------------------------
   // Writes to unmapped addresses are dropped
   wire wr_req = reg_wr && sel_req;
   wire wr_mask = reg_wr && sel_mask;
   wire wr_stoprec = reg_wr && sel_stoprec;
   wire wr_stat = reg_wr && sel_stat;
   wire wr_ien = reg_wr && sel_ien;

   // ------------------------------------------------------------
   // Instruction events
   // ------------------------------------------------------------
   // Enable wins when both instructions arrive together
   wire master_set = enable_interrupts_instr;
   wire master_clr = disable_interrupts_instr && !enable_interrupts_instr;

   // ------------------------------------------------------------
   // Wake events
   // ------------------------------------------------------------
   wire wake_dly = stop_wake && stoprec_q[`IMWD_STOPREC_DLY];
   wire wake_now = stop_wake && !stoprec_q[`IMWD_STOPREC_DLY];

   // ------------------------------------------------------------
   // Request gating, one slice per source
   // ------------------------------------------------------------
   wire master = mask_q[`IMWD_MASK_MASTER];
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_src
         // Request, own enable and master all needed
         assign core_req[g] = req_q[g] & mask_q[g] & master;
      end
   endgenerate

   // ------------------------------------------------------------
   // Interrupt outputs
   // ------------------------------------------------------------
   assign core_irq = |core_req;
   assign irq = |(stat_q & ien_q);

   // ------------------------------------------------------------
   // Mask register
   // ------------------------------------------------------------
   always @* begin
      mask_d = mask_q;
      if (wr_mask) begin
         // Master bit kept; only instructions alter it
         mask_d[NSRC-1:0] = reg_wdata[NSRC-1:0];
         mask_d[`IMWD_MASK_RSVD] = 1'b1;
      end
      if (master_set) begin
         mask_d[`IMWD_MASK_MASTER] = 1'b1;
      end else if (master_clr) begin
         mask_d[`IMWD_MASK_MASTER] = 1'b0;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         mask_q <= `IMWD_MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   // ------------------------------------------------------------
   // Request bits
   // ------------------------------------------------------------
   always @* begin
      req_d = req_q;
      for (k = 0; k < NSRC; k = k + 1) begin
         if (wr_req) begin
            req_d[k] = reg_wdata[k];
         end
         if (service_ack[k]) begin
            req_d[k] = 1'b0;
         end
         // Source set wins over service or software clear
         if (src_event[k]) begin
            req_d[k] = 1'b1;
         end
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         req_q <= `IMWD_REQ_RST;
      end else begin
         req_q <= req_d;
      end
   end

   // ------------------------------------------------------------
   // Stop recovery control
   // ------------------------------------------------------------
   always @* begin
      stoprec_d = stoprec_q;
      if (wr_stoprec) begin
         stoprec_d = reg_wdata;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         stoprec_q <= `IMWD_STOPREC_RST;
      end else begin
         stoprec_q <= stoprec_d;
      end
   end

   // ------------------------------------------------------------
   // Wake delay
   // ------------------------------------------------------------
   always @* begin
      wake_st_d = wake_st_q;
      dly_cnt_d = dly_cnt_q;
      exec_enable_d = exec_enable;
      case (wake_st_q)
         ST_RUN: begin
            if (wake_dly) begin
               wake_st_d = ST_WAIT;
               exec_enable_d = 1'b0;
               dly_cnt_d = DLY_START;
            end else if (wake_now) begin
               exec_enable_d = 1'b1;
            end
         end
         ST_WAIT: begin
            if (wake_dly) begin
               // A fresh wake restarts the count
               dly_cnt_d = DLY_START;
            end else if (wake_now) begin
               wake_st_d = ST_RUN;
               exec_enable_d = 1'b1;
            end else if (dly_cnt_q == DLY_LAST) begin
               wake_st_d = ST_RUN;
               exec_enable_d = 1'b1;
            end else begin
               dly_cnt_d = dly_cnt_q + DLY_STEP;
            end
         end
         default: begin
            wake_st_d = ST_RUN;
            exec_enable_d = 1'b1;
         end
      endcase
   end

   always @(posedge clock) begin
      if (srst) begin
         wake_st_q <= ST_RUN;
         dly_cnt_q <= DLY_START;
         exec_enable <= 1'b1;
      end else begin
         wake_st_q <= wake_st_d;
         dly_cnt_q <= dly_cnt_d;
         exec_enable <= exec_enable_d;
      end
   end

   // ------------------------------------------------------------
   // Sticky status: bit0 request rise, bit1 delay done
   // ------------------------------------------------------------
   wire irq_rise = core_irq && !core_irq_dly_q;
   wire dly_done = (wake_st_q == ST_WAIT) && !stop_wake && (dly_cnt_q == DLY_LAST);
   wire [1:0] stat_ev = {dly_done, irq_rise};

   always @* begin
      stat_d = stat_q;
      if (wr_stat) begin
         stat_d = stat_q & ~reg_wdata[1:0];
      end
      // Set wins over a clear in the same cycle
      stat_d = stat_d | stat_ev;
   end

   always @(posedge clock) begin
      if (srst) begin
         stat_q <= 2'b00;
      end else begin
         stat_q <= stat_d;
      end
   end

   // ------------------------------------------------------------
   // Interrupt enable and edge history
   // ------------------------------------------------------------
   always @* begin
      ien_d = ien_q;
      core_irq_dly_d = core_irq;
      if (wr_ien) begin
         ien_d = reg_wdata[1:0];
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         ien_q <= 2'b00;
         core_irq_dly_q <= 1'b0;
      end else begin
         ien_q <= ien_d;
         core_irq_dly_q <= core_irq_dly_d;
      end
   end

   // ------------------------------------------------------------
   // Read-back views
   // ------------------------------------------------------------
   // Unused upper bits read as zero
   wire [7:0] req_view = {{(8-NSRC){1'b0}}, req_q};
   wire [7:0] stat_view = {6'h00, stat_q};
   wire [7:0] ien_view = {6'h00, ien_q};

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always @* begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `IMWD_ADDR_MASK: begin
               rdata_d = mask_q;
            end
            `IMWD_ADDR_REQ: begin
               rdata_d = req_view;
            end
            `IMWD_ADDR_STOPREC: begin
               rdata_d = stoprec_q;
            end
            `IMWD_ADDR_STAT: begin
               rdata_d = stat_view;
            end
            `IMWD_ADDR_IEN: begin
               rdata_d = ien_view;
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_d;
      end
   end
endmodule // imwd_top
`default_nettype wire

// ---- tb/imwd_chk.sv ----
// Checker for imwd_top: request gating, read port, wake timing.
// Bound to imwd_top; one clock, srst synchronous high.
`timescale 1ns/10ps
`default_nettype none
module imwd_chk #(parameter int NSRC = 6, parameter int TP = 20) (
   input wire clock, srst, reg_rd, core_irq, stop_wake, exec_enable, // Controls
   input wire disable_interrupts_instr, // Disable pulse
   input wire [7:0] reg_addr, reg_rdata, // Register port
   input wire [NSRC-1:0] service_ack, core_req // Core side
);
   localparam int TM = TP - 1;
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   gate_off_a: assert property ($past(disable_interrupts_instr) |-> !core_req)
      else $error("request with master off");
   rst_off_a: assert property ($past(srst) |-> !core_req) else $error("request at reset");
   any_req_a: assert property (core_irq == |core_req) else $error("core_irq wrong");
   rd_idle_a: assert property (!$past(reg_rd) |-> !reg_rdata) else $error("stray data");
   rsvd_one_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hFB |-> reg_rdata[6])
      else $error("reserved bit low");
   svc_clr_a: assert property (|$past(service_ack) |-> !(core_req & $past(service_ack)))
      else $error("serviced request kept");
   wake_src_a: assert property ($fell(exec_enable) |-> $past(stop_wake))
      else $error("stall without wake");
   wake_len_a: assert property ($fell(exec_enable) |-> ##TM !exec_enable ##1 exec_enable)
      else $error("wake delay length");
endmodule // imwd_chk
bind imwd_top imwd_chk #(.NSRC(NSRC), .TP(TPOR_CYC)) imwd_chk_i (.*);
`default_nettype wire

// ---- tb/imwd_core_model.sv ----
// Core model: services the lowest gated request, soon or late.
// Same clock and reset as the block.
`timescale 1ns/10ps
`default_nettype none
module imwd_core_model (
   input wire logic clock, srst, slow, // Clock, reset, long wait
   input wire logic [5:0] core_req, // Gated requests
   output logic [5:0] service_ack // One-hot service pulse
);
   logic [2:0] wait_q;
   always @(posedge clock) begin
      service_ack <= 6'h00;
      wait_q <= (srst || !core_req || |service_ack) ? 3'h0 : wait_q + 3'h1;
      if (!srst && |core_req && !service_ack && wait_q >= (slow ? 3'h5 : 3'h1))
         service_ack <= core_req & -core_req;
   end
endmodule // imwd_core_model
`default_nettype wire

// ---- tb/interrupt_mask_and_wake_delay_bench.sv ----
// Bench: random mask and request rounds, then stop wake timing.
// Needs imwd_top, its bound checker and the core model.
`timescale 1ns/10ps
`default_nettype none
module interrupt_mask_and_wake_delay_bench;
   localparam int TP = 20;
   logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, slow = 0, exec_enable, irq;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, m, q;
   logic [5:0] service_ack, core_req, evt = 6'h00;
   logic [2:0] ins = 3'h0;
   int err_total = 0, checks = 0, seed = 32'hD5428982, i, n;
   imwd_top #(.TPOR_CYC(TP)) imwd_top_i (.*, .src_event(evt), .core_irq(),
      .enable_interrupts_instr(ins[2]), .disable_interrupts_instr(ins[1]), .stop_wake(ins[0]));
   imwd_core_model imwd_core_model_i (.*);
   initial forever #50 clock = ~clock;
   task automatic chk(input logic [7:0] seen, exp, input string nm);
      checks++;
      if (seen !== exp) err_total++;
      if (seen !== exp) $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
   endtask
   task automatic stop_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] ad, wv);
      @(posedge clock);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {ad, wv, wr, !wr};
      @(posedge clock);
      {reg_wr, reg_rd} <= 2'b00;
      #1 rv = reg_rdata;
   endtask
   task automatic op(input logic [2:0] k);
      @(posedge clock);
      ins <= k;
      @(posedge clock);
      ins <= 3'h0;
      #1;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      bus(0, 8'hFB, 8'h00);
      chk(rv, 8'h40, "mask_rst");
      bus(0, 8'h33, 8'h00);
      chk(rv, 8'h00, "unmapped");
      bus(1, 8'hE1, 8'h01);
      for (i = 0; i < 16; i++) begin
         slow <= i[0];
         op(3'h2);
         q = $random(seed);
         m = {2'b01, q[5:0]};
         bus(1, 8'hFB, q | 8'h40);
         bus(0, 8'hFB, 8'h00);
         chk(rv, m, "mask");
         q = $random(seed) & 8'h3F;
         bus(1, 8'hFA, q);
         chk(core_req, 8'h00, "req_off");
         op(3'h4);
         chk(core_req, q & m & 8'h3F, "req_on");
         for (n = 0; n < 80 && core_req !== 6'h00; n++) #100;
         if (n == 80) begin err_total++; stop_test(); end
         chk(irq, |(q & m & 8'h3F), "irq");
         bus(1, 8'hE0, 8'h01);
         chk(irq, 8'h00, "irq_clr");
         bus(0, 8'hFA, 8'h00);
         chk(rv & 8'h3F, q & ~m & 8'h3F, "req_left");
      end
      bus(1, 8'h0B, 8'h20);
      op(3'h1);
      chk(exec_enable, 8'h00, "exec_low");
      repeat (TP - 1) @(posedge clock);
      #1 chk(exec_enable, 8'h00, "exec_hold");
      @(posedge clock);
      #1 chk(exec_enable, 8'h01, "exec_back");
      bus(0, 8'hE0, 8'h00);
      chk(rv, 8'h02, "dly_done");
      bus(1, 8'hE1, 8'h02);
      chk(irq, 8'h01, "irq_dly");
      bus(1, 8'h0B, 8'h00);
      op(3'h1);
      chk(exec_enable, 8'h01, "exec_now");
      op(3'h2);
      m = q & ~m & 8'h3F;
      q = $random(seed);
      @(posedge clock);
      evt <= q[5:0];
      @(posedge clock);
      evt <= 6'h00;
      bus(0, 8'hFA, 8'h00);
      chk(rv, m | (q & 8'h3F), "req_evt");
      @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      bus(0, 8'hFB, 8'h00);
      chk(rv, 8'h40, "mask_rst2");
      stop_test();
   end
endmodule // interrupt_mask_and_wake_delay_bench
`default_nettype wire
